// *** verilog/apmc_pkg.sv ***
// package of constants for the power-management channel mailbox
// Notes on behaviour
// - host data-port write loads input buffer
// - host command-port write loads same buffer
// - status bit 3 records last write's port
// - input-full sets on host write, clears on ec in-alias read
// - output-full sets on ec out-alias write, clears on host data read
// - host data read returns latest output byte
// - data and command ports decoded by selector
// - status bits 7-4 general signalling field
// - status bit 2 spare read/write flag
// - ec block based at 1500h or 1510h
// - ec registers at offsets 00h through 08h
// - sci-alias read clears input-full, raises sci
// - sci-alias write stores byte, raises sci
// - smi-alias write stores byte, raises smi
package apmc_pkg;
   localparam logic [15:0] APMC_BASE_CH1 = 16'h1500;
   localparam logic [15:0] APMC_BASE_CH2 = 16'h1510;

   localparam logic [3:0] OFS_EC_STATUS_VIEW = 4'h0;
   localparam logic [3:0] OFS_EC_PLAIN_OUT = 4'h1;
   localparam logic [3:0] OFS_EC_OUT_WITH_SCI = 4'h2;
   localparam logic [3:0] OFS_EC_OUT_WITH_SMI = 4'h3;
   localparam logic [3:0] OFS_EC_PLAIN_IN = 4'h4;
   localparam logic [3:0] OFS_EC_IN_WITH_SCI = 4'h5;
   localparam logic [3:0] OFS_CHANNEL_CONTROL = 4'h6;
   localparam logic [3:0] OFS_INTERRUPT_CONTROL = 4'h7;
   localparam logic [3:0] OFS_INTERRUPT_ENABLE = 4'h8;

   // status field positions
   localparam int STS_OUTPUT_FULL = 0;
   localparam int STS_INPUT_FULL = 1;
   localparam int STS_SPARE_FLAG = 2;
   localparam int STS_COMMAND_INDICATOR = 3;
   localparam int STS_SIGNAL_LO = 4;
   localparam int STS_SIGNAL_HI = 7;

   // interrupt_enable field positions
   localparam int IE_IRQ_EN = 0;
   localparam int IE_SMI_EN = 1;
   localparam int IE_SCI_EN = 2;

   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [3:0] RST_SIGNAL = 4'h0;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   localparam int RESP_DEPTH = 2;
   localparam logic [1:0] RESP_FULL_COUNT = 2'h2;
endpackage

// *** verilog/apmc_mailbox.sv ***
// power-management channel mailbox: host port, ec register block, response buffer
`timescale 1ns/100ps
`default_nettype none
module apmc_mailbox
   import apmc_pkg::*;
#(
   parameter bit CHANNEL_TWO = 1'b0
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   // host side, already decoded from i/o cycles
   input wire logic hostWrite,
   input wire logic hostRead,
   input wire logic hostCmdSel,
   input wire logic [7:0] hostWriteData,
   output logic [7:0] hostReadData,
   output logic hostReadValid,
   // embedded processor side
   input wire logic ecReqValid,
   output logic ecReqReady,
   input wire logic ecReqWrite,
   input wire logic [15:0] ecAddr,
   input wire logic [7:0] ecWriteData,
   output logic ecRespValid,
   input wire logic ecRespReady,
   output logic [7:0] ecRespData,
   // host interrupt levels
   output logic irqOut,
   output logic sciOut,
   output logic smiOut
);
   logic [1:0] resetSync_reg;
   logic rstN;

   logic [7:0] inputByte_reg;
   logic [7:0] outputByte_reg;
   logic inputFull_reg;
   logic outputFull_reg;
   logic commandIndicator_reg;
   logic spareFlag_reg;
   logic [3:0] signallingField_reg;
   logic [7:0] channelControl_reg;
   logic [7:0] interruptControl_reg;
   logic [7:0] interruptEnable_reg;
   logic obfSmi_reg;
   logic obfSci_reg;
   logic ibfSci_reg;

   logic [7:0] hostReadData_reg;
   logic hostReadValid_reg;

   logic [7:0] respMem_reg [RESP_DEPTH];
   logic respWrPtr_reg;
   logic respRdPtr_reg;
   logic [1:0] respCount_reg;

   logic [15:0] ecBase;
   logic ecHit;
   logic [3:0] ecOfs;
   logic ecAccept;
   logic ecWr;
   logic ecRd;
   logic hostAnyWrite;
   logic hostDataRead;
   logic ecOutWrite;
   logic ecInRead;
   logic ecPlainOutWrite;
   logic ecSciOutWrite;
   logic ecSmiOutWrite;
   logic ecPlainInRead;
   logic ecSciInRead;
   logic ecStatusWrite;
   logic ecControlWrite;
   logic ecIntCtrlWrite;
   logic ecIntEnWrite;
   logic [7:0] statusView;
   logic [7:0] ecReadByte;
   logic respPush;
   logic respPop;

   // the rest of the design sees a reset released on the clock
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         resetSync_reg <= 2'h0;
      end else begin
         resetSync_reg <= {resetSync_reg[0], 1'b1};
      end
   end
   assign rstN = resetSync_reg[1];

   // ec-side address decode
   assign ecBase = CHANNEL_TWO ? APMC_BASE_CH2 : APMC_BASE_CH1;
   assign ecHit = (ecAddr[15:4] == ecBase[15:4]);
   assign ecOfs = ecAddr[3:0];
   assign ecAccept = ecReqValid && ecReqReady;
   assign ecWr = ecAccept && ecReqWrite && ecHit;
   assign ecRd = ecAccept && !ecReqWrite;

   // one strobe per ec alias; offsets 9h-fh and writes to the in aliases do nothing
   always_comb begin
      ecStatusWrite = 1'b0;
      ecPlainOutWrite = 1'b0;
      ecSciOutWrite = 1'b0;
      ecSmiOutWrite = 1'b0;
      ecControlWrite = 1'b0;
      ecIntCtrlWrite = 1'b0;
      ecIntEnWrite = 1'b0;
      ecPlainInRead = 1'b0;
      ecSciInRead = 1'b0;
      if (ecWr) begin
         unique case (ecOfs)
            OFS_EC_STATUS_VIEW: ecStatusWrite = 1'b1;
            OFS_EC_PLAIN_OUT: ecPlainOutWrite = 1'b1;
            OFS_EC_OUT_WITH_SCI: ecSciOutWrite = 1'b1;
            OFS_EC_OUT_WITH_SMI: ecSmiOutWrite = 1'b1;
            OFS_CHANNEL_CONTROL: ecControlWrite = 1'b1;
            OFS_INTERRUPT_CONTROL: ecIntCtrlWrite = 1'b1;
            OFS_INTERRUPT_ENABLE: ecIntEnWrite = 1'b1;
            default: ecStatusWrite = 1'b0;
         endcase
      end
      if (ecRd && ecHit) begin
         unique case (ecOfs)
            OFS_EC_PLAIN_IN: ecPlainInRead = 1'b1;
            OFS_EC_IN_WITH_SCI: ecSciInRead = 1'b1;
            default: ecPlainInRead = 1'b0;
         endcase
      end
   end
   assign ecOutWrite = ecPlainOutWrite || ecSciOutWrite || ecSmiOutWrite;
   assign ecInRead = ecPlainInRead || ecSciInRead;

   // host-side port decode
   assign hostAnyWrite = hostWrite;
   assign hostDataRead = hostRead && !hostCmdSel;

   assign statusView = {signallingField_reg, commandIndicator_reg, spareFlag_reg,
                        inputFull_reg, outputFull_reg};

   // input buffer: both host ports land here
   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) begin
         inputByte_reg <= RST_BYTE;
      end else if (hostAnyWrite) begin
         inputByte_reg <= hostWriteData;
      end
   end

   // the ec tells data from commands only by this bit, so it follows every write
   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) begin
         commandIndicator_reg <= 1'b0;
      end else if (hostAnyWrite) begin
         commandIndicator_reg <= hostCmdSel;
      end
   end

   // set wins when the host writes in the cycle the ec drains the byte
   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) begin
         inputFull_reg <= 1'b0;
      end else if (hostAnyWrite) begin
         inputFull_reg <= 1'b1;
      end else if (ecInRead) begin
         inputFull_reg <= 1'b0;
      end
   end

   // output buffer, written through any of the three out aliases
   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) begin
         outputByte_reg <= RST_BYTE;
      end else if (ecOutWrite) begin
         outputByte_reg <= ecWriteData;
      end
   end

   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) begin
         outputFull_reg <= 1'b0;
      end else if (ecOutWrite) begin
         outputFull_reg <= 1'b1;
      end else if (hostDataRead) begin
         outputFull_reg <= 1'b0;
      end
   end

   // general-purpose status bits are written by the ec only; the host status
   // port is read-only because a host write there is a command byte
   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) begin
         signallingField_reg <= RST_SIGNAL;
      end else if (ecStatusWrite) begin
         signallingField_reg <= ecWriteData[STS_SIGNAL_HI:STS_SIGNAL_LO];
      end
   end

   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) begin
         spareFlag_reg <= 1'b0;
      end else if (ecStatusWrite) begin
         spareFlag_reg <= ecWriteData[STS_SPARE_FLAG];
      end
   end

   // plain storage registers; only interrupt_enable steers logic here
   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) begin
         channelControl_reg <= RST_BYTE;
      end else if (ecControlWrite) begin
         channelControl_reg <= ecWriteData;
      end
   end

   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) begin
         interruptControl_reg <= RST_BYTE;
      end else if (ecIntCtrlWrite) begin
         interruptControl_reg <= ecWriteData;
      end
   end

   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) begin
         interruptEnable_reg <= RST_BYTE;
      end else if (ecIntEnWrite) begin
         interruptEnable_reg <= ecWriteData;
      end
   end

   // smi/sci from the output aliases live as long as output-full does;
   // a plain write drops both so the host is not signalled twice
   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) begin
         obfSmi_reg <= 1'b0;
      end else if (ecOutWrite) begin
         obfSmi_reg <= ecSmiOutWrite && interruptEnable_reg[IE_SMI_EN];
      end else if (hostDataRead) begin
         obfSmi_reg <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) begin
         obfSci_reg <= 1'b0;
      end else if (ecOutWrite) begin
         obfSci_reg <= ecSciOutWrite && interruptEnable_reg[IE_SCI_EN];
      end else if (hostDataRead) begin
         obfSci_reg <= 1'b0;
      end
   end

   // sci from the in alias stands until the host sends the next byte
   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) begin
         ibfSci_reg <= 1'b0;
      end else if (ecSciInRead && interruptEnable_reg[IE_SCI_EN]) begin
         ibfSci_reg <= 1'b1;
      end else if (hostAnyWrite) begin
         ibfSci_reg <= 1'b0;
      end
   end

   assign sciOut = obfSci_reg || ibfSci_reg;
   assign smiOut = obfSmi_reg;
   assign irqOut = outputFull_reg && interruptEnable_reg[IE_IRQ_EN];

   // host read answer, one cycle after the strobe
   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) begin
         hostReadValid_reg <= 1'b0;
      end else begin
         hostReadValid_reg <= hostRead;
      end
   end

   // the byte stays put between reads so a slow host can still pick it up
   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) begin
         hostReadData_reg <= RST_BYTE;
      end else if (hostRead) begin
         hostReadData_reg <= hostCmdSel ? statusView : outputByte_reg;
      end
   end
   assign hostReadData = hostReadData_reg;
   assign hostReadValid = hostReadValid_reg;

   // ec read data; the write-only aliases and gaps read as zero
   always_comb begin
      ecReadByte = UNMAPPED_READ;
      if (ecHit) begin
         unique case (ecOfs)
            OFS_EC_STATUS_VIEW: ecReadByte = statusView;
            OFS_EC_PLAIN_IN: ecReadByte = inputByte_reg;
            OFS_EC_IN_WITH_SCI: ecReadByte = inputByte_reg;
            OFS_CHANNEL_CONTROL: ecReadByte = channelControl_reg;
            OFS_INTERRUPT_CONTROL: ecReadByte = interruptControl_reg;
            OFS_INTERRUPT_ENABLE: ecReadByte = interruptEnable_reg;
            default: ecReadByte = UNMAPPED_READ;
         endcase
      end
   end

   // two-entry response buffer: a stalled reader holds the request port,
   // so no side-effecting read is taken without room for its answer
   assign ecReqReady = (respCount_reg != RESP_FULL_COUNT);
   assign respPush = ecRd;
   assign respPop = ecRespValid && ecRespReady;
   assign ecRespValid = (respCount_reg != 2'h0);
   assign ecRespData = respMem_reg[respRdPtr_reg];

   genvar gi;
   generate
      for (gi = 0; gi < RESP_DEPTH; gi++) begin : g_resp
         always_ff @(posedge sys_clk or negedge rstN) begin
            if (!rstN) begin
               respMem_reg[gi] <= RST_BYTE;
            end else if (respPush && (respWrPtr_reg == 1'(gi))) begin
               respMem_reg[gi] <= ecReadByte;
            end
         end
      end
   endgenerate

   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) begin
         respWrPtr_reg <= 1'b0;
         respRdPtr_reg <= 1'b0;
         respCount_reg <= 2'h0;
      end else begin
         if (respPush) begin
            respWrPtr_reg <= ~respWrPtr_reg;
         end
         if (respPop) begin
            respRdPtr_reg <= ~respRdPtr_reg;
         end
         if (respPush && !respPop) begin
            respCount_reg <= respCount_reg + 2'h1;
         end else if (respPop && !respPush) begin
            respCount_reg <= respCount_reg - 2'h1;
         end
      end
   end
endmodule
`default_nettype wire

// *** verification/apmc_host_model.sv ***
// host processor stand-in driving the mailbox host port
`timescale 1ns/100ps
`default_nettype none
module apmc_host_model (
   input wire logic sys_clk,
   output logic hostWrite,
   output logic hostRead,
   output logic hostCmdSel,
   output logic [7:0] hostWriteData,
   input wire logic [7:0] hostReadData,
   input wire logic hostReadValid
);
   logic [7:0] rdByte;
   initial begin
      hostWrite = 1'b0;
      hostRead = 1'b0;
      hostCmdSel = 1'b0;
      hostWriteData = 8'h00;
      rdByte = 8'h00;
   end
   // legacy channel one ports: 62h data, 66h command and status
   task automatic io(input logic wr, input logic [7:0] port, input logic [7:0] d);
      // an idle edge first, so back-to-back calls never reassign a strobe at once
      @(posedge sys_clk);
      #1;
      hostCmdSel = (port == 8'h66);
      hostWriteData = d;
      hostWrite = wr;
      hostRead = !wr;
      @(posedge sys_clk);
      #1;
      hostWrite = 1'b0;
      hostRead = 1'b0;
      // released lines do not keep the last value
      hostWriteData = ~d;
      hostCmdSel = ~hostCmdSel;
      rdByte = hostReadData;
   endtask
endmodule
`default_nettype wire

// *** verification/apmc_mailbox_assertions.sv ***
// port relations of the mailbox, bound to its top module
`timescale 1ns/100ps
`default_nettype none
module apmc_mailbox_assertions (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic hostWrite,
   input wire logic hostRead,
   input wire logic hostCmdSel,
   input wire logic [7:0] hostWriteData,
   input wire logic [7:0] hostReadData,
   input wire logic hostReadValid,
   input wire logic ecReqValid,
   input wire logic ecReqReady,
   input wire logic ecReqWrite,
   input wire logic [15:0] ecAddr,
   input wire logic [7:0] ecWriteData,
   input wire logic ecRespValid,
   input wire logic ecRespReady,
   input wire logic [7:0] ecRespData,
   input wire logic irqOut,
   input wire logic sciOut,
   input wire logic smiOut
);
   default clocking dc @(posedge sys_clk);
   endclocking
   default disable iff (!reset_n);
   // an ec out write at the same edge wins, so it is left out
   sequence s_data_read;
      hostRead && !hostCmdSel && !(ecReqValid && ecReqReady && ecReqWrite);
   endsequence
   sequence s_ec_read;
      ecReqValid && ecReqReady && !ecReqWrite;
   endsequence
   a_read_answer: assert property (hostRead |=> hostReadValid) else $error("late answer");
   a_answer_cause: assert property (hostReadValid |-> $past(hostRead)) else $error("stray");
   a_data_hold: assert property (!$past(hostRead) |-> $stable(hostReadData)) else $error("drift");
   a_irq_drop: assert property (s_data_read |=> !irqOut) else $error("irq kept");
   a_smi_drop: assert property (s_data_read |=> !smiOut) else $error("smi kept");
   a_status_quiet: assert property (hostRead && hostCmdSel && !ecReqValid |=>
      $stable(irqOut) && $stable(smiOut) && $stable(sciOut)) else $error("side effect");
   a_resp_wait: assert property (ecRespValid && !ecRespReady |=>
      ecRespValid && $stable(ecRespData)) else $error("answer lost");
   a_full_stall: assert property (!ecReqReady |-> ecRespValid) else $error("bad stall");
   a_read_resp: assert property (s_ec_read |=> ecRespValid) else $error("no answer");
endmodule
bind apmc_mailbox apmc_mailbox_assertions i_chk (.sys_clk, .reset_n, .hostWrite, .hostRead,
   .hostCmdSel, .hostWriteData, .hostReadData, .hostReadValid, .ecReqValid, .ecReqReady,
   .ecReqWrite, .ecAddr, .ecWriteData, .ecRespValid, .ecRespReady, .ecRespData, .irqOut,
   .sciOut, .smiOut);
`default_nettype wire

// *** verification/apmc_mailbox_tb.sv ***
// self-checking bench for the mailbox
`timescale 1ns/100ps
`default_nettype none
module apmc_mailbox_tb;
   import apmc_pkg::*;
   typedef struct {logic [3:0] o; logic [7:0] d; logic [7:0] ie; logic sci; logic smi;
      logic irq;} apmc_row_t;
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   logic hostWrite, hostRead, hostCmdSel, hostReadValid, ecReqReady, ecRespValid;
   logic irqOut, sciOut, smiOut;
   logic [7:0] hostWriteData, hostReadData, ecRespData, ecRd;
   logic ecReqValid = 1'b0;
   logic ecReqWrite = 1'b0;
   logic ecRespReady = 1'b1;
   logic [15:0] ecAddr = 16'h0000;
   logic [7:0] ecWriteData = 8'h00;
   int mismatches = 0;
   int compares = 0;
   int cyc = 0;
   apmc_row_t rows [6] = '{'{4'h1, 8'h11, 8'h07, 1'h0, 1'h0, 1'h1},
      '{4'h2, 8'h22, 8'h04, 1'h1, 1'h0, 1'h0}, '{4'h2, 8'h33, 8'h00, 1'h0, 1'h0, 1'h0},
      '{4'h3, 8'h44, 8'h02, 1'h0, 1'h1, 1'h0}, '{4'h3, 8'hff, 8'h01, 1'h0, 1'h0, 1'h1},
      '{4'h1, 8'h00, 8'h06, 1'h0, 1'h0, 1'h0}};
   apmc_mailbox #(.CHANNEL_TWO(1'b0)) i_apmc_mailbox (.sys_clk, .reset_n, .hostWrite,
      .hostRead, .hostCmdSel, .hostWriteData, .hostReadData, .hostReadValid, .ecReqValid,
      .ecReqReady, .ecReqWrite, .ecAddr, .ecWriteData, .ecRespValid, .ecRespReady,
      .ecRespData, .irqOut, .sciOut, .smiOut);
   apmc_host_model i_apmc_host_model (.sys_clk, .hostWrite, .hostRead, .hostCmdSel,
      .hostWriteData, .hostReadData, .hostReadValid);
   always #2.5 sys_clk = ~sys_clk;
   task automatic close_out();
      if (mismatches == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 4000) begin
         mismatches++;
         close_out();
      end
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %0t seen %h want %h", $time, seen, exp);
      end
   endtask
   // readiness only moves at edges, so sampling it after the edge is safe
   task automatic ereq(input logic wr, input logic [15:0] a, input logic [7:0] d);
      logic rdy;
      // an idle edge first, so back-to-back calls never reassign the strobe at once
      @(posedge sys_clk);
      #1;
      ecReqValid = 1'b1;
      ecReqWrite = wr;
      ecAddr = a;
      ecWriteData = d;
      do begin
         rdy = ecReqReady;
         @(posedge sys_clk);
      end while (!rdy);
      #1;
      ecReqValid = 1'b0;
      ecAddr = ~a;
      ecWriteData = ~d;
   endtask
   task automatic ec(input logic wr, input logic [3:0] o, input logic [7:0] d);
      int n;
      ereq(wr, APMC_BASE_CH1 + 16'(o), d);
      for (n = 0; n < 20 && !wr && ecRespValid !== 1'b1; n++) @(posedge sys_clk) #1;
      ecRd = ecRespData;
      if (!wr) begin
         @(posedge sys_clk);
         #1;
      end
   endtask
   initial begin
      apmc_row_t r;
      repeat (20) @(posedge sys_clk);
      #1;
      reset_n = 1'b1;
      repeat (3) @(posedge sys_clk);
      #1;
      check(8'({irqOut, smiOut, sciOut, hostReadValid, ecRespValid}), 8'h00);
      i_apmc_host_model.io(1'b0, 8'h66, 8'h00);
      check(i_apmc_host_model.rdByte, 8'h00);
      foreach (rows[i]) begin
         r = rows[i];
         ec(1'b1, OFS_INTERRUPT_ENABLE, r.ie);
         ec(1'b1, r.o, r.d);
         check(8'(sciOut), 8'(r.sci));
         check(8'(smiOut), 8'(r.smi));
         check(8'(irqOut), 8'(r.irq));
         ec(1'b0, OFS_EC_STATUS_VIEW, 8'h00);
         check(ecRd, 8'h01);
         i_apmc_host_model.io(1'b0, 8'h62, 8'h00);
         check(i_apmc_host_model.rdByte, r.d);
         check(8'({irqOut, smiOut, sciOut}), 8'h00);
      end
      i_apmc_host_model.io(1'b1, 8'h62, 8'h5a);
      ec(1'b0, OFS_EC_STATUS_VIEW, 8'h00);
      check(ecRd, 8'h02);
      ec(1'b0, OFS_EC_PLAIN_IN, 8'h00);
      check(ecRd, 8'h5a);
      check(8'(sciOut), 8'h00);
      i_apmc_host_model.io(1'b1, 8'h66, 8'ha5);
      i_apmc_host_model.io(1'b0, 8'h66, 8'h00);
      check(i_apmc_host_model.rdByte, 8'h0a);
      ec(1'b0, OFS_EC_IN_WITH_SCI, 8'h00);
      check(ecRd, 8'ha5);
      check(8'(sciOut), 8'h01);
      ec(1'b1, OFS_EC_STATUS_VIEW, 8'hff);
      ec(1'b0, OFS_EC_STATUS_VIEW, 8'h00);
      check(ecRd, 8'hfc);
      i_apmc_host_model.io(1'b1, 8'h62, 8'h01);
      check(8'(sciOut), 8'h00);
      i_apmc_host_model.io(1'b0, 8'h66, 8'h00);
      check(i_apmc_host_model.rdByte, 8'hf6);
      ec(1'b1, OFS_CHANNEL_CONTROL, 8'h3c);
      // receiver stalls: two answers fill the buffer and requests wait
      ecRespReady = 1'b0;
      ereq(1'b0, 16'h1520, 8'h00);
      ereq(1'b0, APMC_BASE_CH1 + 16'(OFS_CHANNEL_CONTROL), 8'h00);
      check(8'({ecReqReady, ecRespValid}), 8'h01);
      ecRespReady = 1'b1;
      check(ecRespData, 8'h00);
      @(posedge sys_clk);
      #1;
      check(ecRespData, 8'h3c);
      @(posedge sys_clk);
      #1;
      check(8'(ecRespValid), 8'h00);
      close_out();
   end
endmodule
`default_nettype wire
